// file: design/amw_pkg.sv
package amw_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_FMT   = 3'h0;
    localparam logic [2:0] ADDR_CTL1  = 3'h1;
    localparam logic [2:0] ADDR_CTL2  = 3'h2;
    localparam logic [2:0] ADDR_RXST  = 3'h3;
    localparam logic [2:0] ADDR_RXBUF = 3'h4;
    localparam logic [2:0] ADDR_TXBUF = 3'h5;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL1_RX_EN   = 0;
    localparam int CTL1_TX_EN   = 1;
    localparam int CTL1_SLEEP   = 2;
    localparam int CTL1_TXWREQ  = 3;
    localparam int CTL2_RX_IEN  = 1;
    localparam int CTL2_TX_EMPT = 6;
    localparam int CTL2_TX_RDY  = 7;
    localparam int RXST_WAKE    = 1;
    localparam int RXST_PE      = 2;
    localparam int RXST_OE      = 3;
    localparam int RXST_FE      = 4;
    localparam int RXST_FULL    = 6;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] FMT_RST   = 8'h07;
    localparam logic [7:0] CTL_RST   = 8'h00;
    localparam int         TICKS_BIT = 8;
    localparam int         START_LOW = 4;
    localparam int         IDLE_RX_BITS = 10;
    localparam int         IDLE_TX_BITS = 11;
    localparam logic [2:0] SAMP_A    = 3'h3;
    localparam logic [2:0] SAMP_B    = 3'h4;
    localparam logic [2:0] SAMP_C    = 3'h5;

    typedef struct packed {
        logic       two_stop;
        logic       par_even;
        logic       par_en;
        logic       rsvd;
        logic       addr_mode;
        logic [2:0] char_len;
    } amw_fmt_type;

    typedef enum logic [6:0] {
        T_IDLE  = 7'b000_0001,
        T_START = 7'b000_0010,
        T_DATA  = 7'b000_0100,
        T_ADDR  = 7'b000_1000,
        T_PAR   = 7'b001_0000,
        T_STOP  = 7'b010_0000,
        T_WAKE  = 7'b100_0000
    } amw_tx_state_type;

    typedef enum logic [2:0] {
        R_HUNT  = 3'b001,
        R_START = 3'b010,
        R_BITS  = 3'b100
    } amw_rx_state_type;
endpackage : amw_pkg

// file: design/amw_uart.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module amw_uart
    import amw_pkg::*;
#(
    parameter int OVS_DIV = 4   // Core clocks per oversample tick
)(
    input  wire logic       core_clk_in,    // 10 MHz core clock
    input  wire logic       rst_b_in,       // Async reset, active low
    input  wire logic [2:0] addr_in,        // Register address
    input  wire logic [7:0] wdata_in,       // Write data
    input  wire logic       wr_in,          // Write strobe
    input  wire logic       rd_in,          // Read strobe
    output logic      [7:0] rdata_out,      // Read data, cycle after strobe
    input  wire logic       serial_in_pin,  // Serial receive line
    output logic            serial_out,     // Serial transmit line
    output logic            rx_irq_out      // Receive interrupt request
);
    initial begin
        if (OVS_DIV < 1 || OVS_DIV > 65536)
        begin
            $error("OVS_DIV must be 1 to 65536");
        end
    end

    // ------------------------------------------------------------
    // Registers and oversample tick
    // ------------------------------------------------------------
    logic [7:0]  frame_format_reg;
    logic [7:0]  control_one_reg;
    logic [7:0]  control_two_reg;
    logic [7:0]  tx_holding_buffer;
    logic        tx_full_reg;
    logic [7:0]  rx_holding_buffer;
    logic        rx_full_flag;
    logic        rx_wake_flag;
    logic [2:0]  rx_err_reg;        // FE, OE, PE
    logic [15:0] div_reg;
    logic        oversample_tick;
    amw_fmt_type fmt;
    logic [3:0]  nbits;
    logic        tx_load;
    logic        tx_busy;
    logic        rd_rxbuf;
    logic        wr_ctl1;

    assign fmt      = amw_fmt_type'(frame_format_reg);
    assign nbits    = {1'b0, fmt.char_len} + 4'h1;
    assign rd_rxbuf = rd_in && (addr_in == ADDR_RXBUF);
    assign wr_ctl1  = wr_in && (addr_in == ADDR_CTL1);

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            div_reg         <= 16'h0000;
            oversample_tick <= 1'b0;
        end
        else if (div_reg == 16'(OVS_DIV - 1))
        begin
            div_reg         <= 16'h0000;
            oversample_tick <= 1'b1;
        end
        else
        begin
            div_reg         <= div_reg + 16'h0001;
            oversample_tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            frame_format_reg <= FMT_RST;
            control_two_reg  <= CTL_RST;
        end
        else if (wr_in && addr_in == ADDR_FMT)
        begin
            frame_format_reg <= wdata_in;
        end
        else if (wr_in && addr_in == ADDR_CTL2)
        begin
            control_two_reg  <= wdata_in;
        end
    end

    // Sleep is written only by the host; a new write beats the load clear
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            control_one_reg <= CTL_RST;
        end
        else if (wr_ctl1)
        begin
            control_one_reg <= wdata_in;
        end
        else if (tx_load)
        begin
            control_one_reg[CTL1_TXWREQ] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tx_holding_buffer <= 8'h00;
            tx_full_reg       <= 1'b0;
        end
        else if (wr_in && addr_in == ADDR_TXBUF)
        begin
            tx_holding_buffer <= wdata_in;
            tx_full_reg       <= 1'b1;
        end
        else if (tx_load)
        begin
            tx_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rdata_out <= 8'h00;
        end
        else if (rd_in)
        begin
            case (addr_in)
                ADDR_FMT:   rdata_out <= frame_format_reg;
                ADDR_CTL1:  rdata_out <= control_one_reg;
                ADDR_CTL2:  rdata_out <= {!tx_full_reg, !tx_full_reg && !tx_busy,
                                          control_two_reg[5:0]};
                ADDR_RXST:  rdata_out <= {1'b0, rx_full_flag, 1'b0, rx_err_reg,
                                          rx_wake_flag, 1'b0};
                ADDR_RXBUF: rdata_out <= rx_holding_buffer;
                default:    rdata_out <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    amw_tx_state_type tx_state_reg;
    logic [7:0]       tx_shift_reg;
    logic             wake_temp_latch;
    logic [2:0]       tx_tick_reg;
    logic [3:0]       tx_bit_reg;
    logic             tx_par_reg;
    logic             tx_bit_end;

    assign tx_busy    = (tx_state_reg != T_IDLE);
    assign tx_load    = !tx_busy && tx_full_reg && control_one_reg[CTL1_TX_EN];
    assign tx_bit_end = oversample_tick && (tx_tick_reg == 3'(TICKS_BIT - 1));

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tx_state_reg    <= T_IDLE;
            tx_shift_reg    <= 8'h00;
            wake_temp_latch <= 1'b0;
            tx_tick_reg     <= 3'h0;
            tx_bit_reg      <= 4'h0;
            tx_par_reg      <= 1'b0;
            serial_out      <= 1'b1;
        end
        else
        begin
            if (oversample_tick)
            begin
                tx_tick_reg <= tx_tick_reg + 3'h1;
            end
            case (tx_state_reg)
                T_IDLE:
                begin
                    serial_out <= 1'b1;
                    if (tx_load)
                    begin
                        tx_shift_reg    <= tx_holding_buffer;
                        wake_temp_latch <= control_one_reg[CTL1_TXWREQ];
                        tx_tick_reg     <= 3'h0;
                        tx_bit_reg      <= 4'h0;
                        tx_par_reg      <= 1'b0;
                        // Idle block start drops the data word entirely
                        if (!fmt.addr_mode && control_one_reg[CTL1_TXWREQ])
                        begin
                            tx_state_reg <= T_WAKE;
                        end
                        else
                        begin
                            tx_state_reg <= T_START;
                            serial_out   <= 1'b0;
                        end
                    end
                end
                T_START:
                begin
                    if (tx_bit_end)
                    begin
                        tx_state_reg <= T_DATA;
                        serial_out   <= tx_shift_reg[0];
                    end
                end
                T_DATA:
                begin
                    if (tx_bit_end)
                    begin
                        tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg   <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg != nbits - 4'h1)
                        begin
                            serial_out <= tx_shift_reg[1];
                        end
                        else if (fmt.addr_mode)
                        begin
                            tx_state_reg <= T_ADDR;
                            serial_out   <= wake_temp_latch;
                        end
                        else if (fmt.par_en)
                        begin
                            tx_state_reg <= T_PAR;
                            serial_out   <= (tx_par_reg ^ tx_shift_reg[0]) ^ !fmt.par_even;
                        end
                        else
                        begin
                            tx_state_reg <= T_STOP;
                            tx_bit_reg   <= 4'h0;
                            serial_out   <= 1'b1;
                        end
                    end
                end
                T_ADDR:
                begin
                    if (tx_bit_end)
                    begin
                        tx_bit_reg <= 4'h0;
                        if (fmt.par_en)
                        begin
                            tx_state_reg <= T_PAR;
                            serial_out   <= tx_par_reg ^ !fmt.par_even;
                        end
                        else
                        begin
                            tx_state_reg <= T_STOP;
                            serial_out   <= 1'b1;
                        end
                    end
                end
                T_PAR:
                begin
                    if (tx_bit_end)
                    begin
                        tx_state_reg <= T_STOP;
                        tx_bit_reg   <= 4'h0;
                        serial_out   <= 1'b1;
                    end
                end
                T_STOP:
                begin
                    if (tx_bit_end)
                    begin
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg == 4'(fmt.two_stop))
                        begin
                            tx_state_reg <= T_IDLE;
                        end
                    end
                end
                T_WAKE:
                begin
                    serial_out <= 1'b1;
                    if (tx_bit_end)
                    begin
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg == 4'(IDLE_TX_BITS - 1))
                        begin
                            tx_state_reg <= T_IDLE;
                        end
                    end
                end
                default:
                begin
                    tx_state_reg <= T_IDLE;
                    serial_out   <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receiver input synchroniser
    // ------------------------------------------------------------
    logic [2:0] rx_sync_reg;
    logic       rx_line;

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_sync_reg <= 3'b111;
            rx_line     <= 1'b1;
        end
        else
        begin
            rx_sync_reg <= {rx_sync_reg[1:0], serial_in_pin};
            if (rx_sync_reg[1] == rx_sync_reg[2])
            begin
                rx_line <= rx_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    amw_rx_state_type rx_state_reg;
    logic [10:0]      rx_shift_reg;
    logic [2:0]       rx_tick_reg;
    logic [3:0]       rx_bit_reg;
    logic [1:0]       rx_samp_reg;
    logic [6:0]       idle_cnt_reg;
    logic             block_start_reg;
    logic [3:0]       rx_total;
    logic             frame_done;
    logic             rx_addr_frame;
    logic             rx_par_bad;
    logic             rx_transfer;

    assign rx_total   = nbits + 4'(fmt.addr_mode) + 4'(fmt.par_en) + 4'h1;
    assign frame_done = oversample_tick && rx_state_reg == R_BITS
                        && rx_tick_reg == 3'(TICKS_BIT - 1) && rx_bit_reg == rx_total - 4'h1;
    // Frame identity: block start in idle-line mode, address bit otherwise
    assign rx_addr_frame = fmt.addr_mode ? rx_shift_reg[nbits] : block_start_reg;
    // Parity spans data bits only, matching the transmitter
    assign rx_par_bad = fmt.par_en && ((^(rx_shift_reg[7:0] & 8'((9'h001 << nbits) - 9'h001)))
                        ^ rx_shift_reg[nbits + 4'(fmt.addr_mode)] ^ !fmt.par_even);
    assign rx_transfer = frame_done && control_one_reg[CTL1_RX_EN]
                         && (!control_one_reg[CTL1_SLEEP] || rx_addr_frame);

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_state_reg <= R_HUNT;
            rx_shift_reg <= 11'h000;
            rx_tick_reg  <= 3'h0;
            rx_bit_reg   <= 4'h0;
            rx_samp_reg  <= 2'b00;
        end
        else if (oversample_tick)
        begin
            case (rx_state_reg)
                R_HUNT:
                begin
                    if (!rx_line)
                    begin
                        rx_state_reg <= R_START;
                        rx_tick_reg  <= 3'h1;
                    end
                end
                R_START:
                begin
                    rx_tick_reg <= rx_tick_reg + 3'h1;
                    if (rx_line && rx_tick_reg < 3'(START_LOW))
                    begin
                        rx_state_reg <= R_HUNT;
                    end
                    else if (rx_tick_reg == 3'(TICKS_BIT - 1))
                    begin
                        rx_state_reg <= R_BITS;
                        rx_bit_reg   <= 4'h0;
                    end
                end
                R_BITS:
                begin
                    rx_tick_reg <= rx_tick_reg + 3'h1;
                    if (rx_tick_reg == SAMP_A)
                    begin
                        rx_samp_reg[0] <= rx_line;
                    end
                    if (rx_tick_reg == SAMP_B)
                    begin
                        rx_samp_reg[1] <= rx_line;
                    end
                    if (rx_tick_reg == SAMP_C)
                    begin
                        rx_shift_reg[rx_bit_reg] <= (rx_samp_reg[0] & rx_samp_reg[1])
                            | (rx_line & (rx_samp_reg[0] | rx_samp_reg[1]));
                    end
                    if (rx_tick_reg == 3'(TICKS_BIT - 1))
                    begin
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (frame_done)
                        begin
                            rx_state_reg <= R_HUNT;
                        end
                    end
                end
                default:
                begin
                    rx_state_reg <= R_HUNT;
                end
            endcase
        end
    end

    // Idle gap counted in ticks; a lone low glitch restarts it
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            idle_cnt_reg    <= 7'h00;
            block_start_reg <= 1'b0;
        end
        else if (frame_done)
        begin
            idle_cnt_reg    <= 7'h00;
            block_start_reg <= 1'b0;
        end
        else if (oversample_tick)
        begin
            if (!rx_line || rx_state_reg != R_HUNT)
            begin
                idle_cnt_reg <= 7'h00;
            end
            else if (idle_cnt_reg != 7'(IDLE_RX_BITS * TICKS_BIT))
            begin
                idle_cnt_reg <= idle_cnt_reg + 7'h01;
            end
            else
            begin
                block_start_reg <= 1'b1;
            end
        end
    end

    // Ready set beats the read clear in the same cycle
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_holding_buffer <= 8'h00;
            rx_full_flag      <= 1'b0;
            rx_wake_flag      <= 1'b0;
            rx_err_reg        <= 3'b000;
        end
        else if (rx_transfer)
        begin
            rx_holding_buffer <= rx_shift_reg[7:0] & 8'((9'h001 << nbits) - 9'h001);
            rx_full_flag      <= 1'b1;
            rx_wake_flag      <= rx_addr_frame;
            rx_err_reg        <= {!rx_shift_reg[rx_total - 4'h1], rx_full_flag, rx_par_bad};
        end
        else if (rd_rxbuf)
        begin
            rx_full_flag <= 1'b0;
        end
    end

    assign rx_irq_out = rx_full_flag && control_two_reg[CTL2_RX_IEN];
endmodule : amw_uart

// file: sim/amw_remote.sv
`timescale 1ns/1ps
module amw_remote (
    input  wire logic tx_line_in,  // Line from block
    input  wire logic glitch_in,   // Spike request
    output logic      rx_line_out  // Line into block
);
    // Echo node; a spike pulls the shared line low
    assign rx_line_out = tx_line_in & ~glitch_in;
endmodule : amw_remote

// file: sim/amw_uart_props.sv
`timescale 1ns/1ps
module amw_uart_props
    import amw_pkg::*;
#(
    parameter int OVS_DIV = 4  // Clocks per tick
)(
    input wire logic       core_clk_in,   // Clock
    input wire logic       rst_b_in,      // Reset
    input wire logic [2:0] addr_in,       // Address
    input wire logic [7:0] wdata_in,      // Write data
    input wire logic       wr_in,         // Write
    input wire logic       rd_in,         // Read
    input wire logic [7:0] rdata_out,     // Read data
    input wire logic       serial_in_pin, // Line in
    input wire logic       serial_out,    // Line out
    input wire logic       rx_irq_out     // Interrupt
);
    logic [7:0] fmt_reg;
    logic [2:0] ctl1_reg;
    logic       ien_reg;
    int         low_reg;
    // Shadows skip the wake request, which hardware clears
    always_ff @(posedge core_clk_in or negedge rst_b_in)
        if (!rst_b_in) fmt_reg <= FMT_RST;
        else if (wr_in && addr_in == ADDR_FMT) fmt_reg <= wdata_in;
    always_ff @(posedge core_clk_in or negedge rst_b_in)
        if (!rst_b_in) ctl1_reg <= '0;
        else if (wr_in && addr_in == ADDR_CTL1) ctl1_reg <= wdata_in[2:0];
    always_ff @(posedge core_clk_in or negedge rst_b_in)
        if (!rst_b_in) ien_reg <= 1'b0;
        else if (wr_in && addr_in == ADDR_CTL2) ien_reg <= wdata_in[CTL2_RX_IEN];
    always_ff @(posedge core_clk_in or negedge rst_b_in)
        if (!rst_b_in) low_reg <= 0;
        else low_reg <= serial_out ? 0 : low_reg + 1;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    irq_needs_en_a: assert property (rx_irq_out |-> ien_reg)
        else $error("irq while disabled");
    read_clears_a: assert property (rd_in && addr_in == ADDR_RXBUF |=> !rx_irq_out)
        else $error("ready kept after read");
    ready_seen_a: assert property (rd_in && addr_in == ADDR_RXST && rx_irq_out
        |=> rdata_out[RXST_FULL]) else $error("ready missing");
    ctl1_back_a: assert property (rd_in && addr_in == ADDR_CTL1
        |=> rdata_out[2:0] == ctl1_reg) else $error("control one altered");
    ctl2_back_a: assert property (rd_in && addr_in == ADDR_CTL2
        |=> rdata_out[CTL2_RX_IEN] == ien_reg) else $error("irq enable lost");
    fmt_back_a: assert property (rd_in && addr_in == ADDR_FMT
        |=> {rdata_out[7:5], rdata_out[3:0]} == {fmt_reg[7:5], fmt_reg[3:0]})
        else $error("format altered");
    bit_time_a: assert property ($rose(serial_out)
        |-> low_reg >= TICKS_BIT * OVS_DIV - OVS_DIV) else $error("short bit");
    rx_gate_a: assert property ($rose(rx_irq_out) && $past(ien_reg)
        |-> $past(ctl1_reg[CTL1_RX_EN])) else $error("transfer while disabled");
    cover property ($rose(rx_irq_out));
    cover property (wr_in && addr_in == ADDR_FMT && wdata_in[3]);
    cover property ($rose(serial_out) && low_reg > TICKS_BIT * OVS_DIV);
endmodule : amw_uart_props

bind amw_uart amw_uart_props #(.OVS_DIV(OVS_DIV)) props (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .serial_in_pin(serial_in_pin),
    .serial_out(serial_out), .rx_irq_out(rx_irq_out));

// file: sim/amw_uart_test.sv
`timescale 1ns/1ps
module amw_uart_test;
    import amw_pkg::*;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       rd_q = 1'b0;
    logic       glitch = 1'b0;
    logic [7:0] rdata;
    logic       line_in;
    logic       line_out;
    logic       irq;
    logic [7:0] b;
    logic [7:0] exp_q[$];
    int         fails = 0;
    int         tests_run = 0;
    int         hi_cnt = 0;
    int         seed;
    always #50 clk = ~clk;
    amw_uart #(.OVS_DIV(1)) dut (.core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .serial_in_pin(line_in), .serial_out(line_out), .rx_irq_out(irq));
    amw_remote remote (.tx_line_in(line_out), .glitch_in(glitch), .rx_line_out(line_in));
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic end_of_test;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] want);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(want);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    // Bounded wait for the interrupt or for a start bit on the line
    task automatic wait_until(input bit on_irq);
        int n;
        n = 0;
        while ((on_irq ? irq !== 1'b1 : line_out !== 1'b0) && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 500)
        begin
            fails++;
            end_of_test();
        end
    endtask : wait_until
    always @(posedge clk)
    begin
        if (rd_q)
            chk(rdata, exp_q.pop_front());
        rd_q <= rd;
        hi_cnt <= line_out ? hi_cnt + 1 : 0;
    end
    initial
    begin
        seed = $urandom(73);
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(ADDR_FMT, 8'h07);
        rd_reg(ADDR_CTL1, 8'h00);
        rd_reg(ADDR_RXST, 8'h00);
        rd_reg(3'h6, 8'h00);
        wr_reg(ADDR_CTL2, 8'h02);
        wr_reg(ADDR_CTL1, 8'h03);
        // Long quiet line, so the first frame opens a block
        repeat (100) @(posedge clk);
        for (int i = 0; i < 2; i++)
        begin
            b = 8'($urandom);
            glitch <= (i == 1);
            repeat (3) @(posedge clk);
            glitch <= 1'b0;
            wr_reg(ADDR_TXBUF, b);
            wait_until(1'b1);
            rd_reg(ADDR_RXST, i == 0 ? 8'h42 : 8'h40);
            rd_reg(ADDR_RXBUF, b);
        end
        b = 8'($urandom) & 8'h7f;
        wr_reg(ADDR_TXBUF, b);
        wr_reg(ADDR_CTL1, 8'h0b);
        wr_reg(ADDR_TXBUF, 8'($urandom));
        wait_until(1'b1);
        rd_reg(ADDR_RXST, 8'h40);
        rd_reg(ADDR_RXBUF, b);
        repeat (16) @(posedge clk);
        rd_reg(ADDR_CTL1, 8'h03);
        b = 8'($urandom);
        wr_reg(ADDR_TXBUF, b);
        wait_until(1'b0);
        chk(8'((hi_cnt + 2) / 8), 8'h0c);
        wait_until(1'b1);
        rd_reg(ADDR_RXST, 8'h42);
        rd_reg(ADDR_RXBUF, b);
        wr_reg(ADDR_FMT, 8'h0f);
        wr_reg(ADDR_CTL1, 8'h07);
        wr_reg(ADDR_TXBUF, 8'($urandom));
        repeat (100) @(posedge clk);
        rd_reg(ADDR_RXST, 8'h02);
        b = 8'($urandom);
        wr_reg(ADDR_CTL1, 8'h0f);
        wr_reg(ADDR_TXBUF, b);
        wait_until(1'b1);
        rd_reg(ADDR_RXST, 8'h42);
        rd_reg(ADDR_RXBUF, b);
        rd_reg(ADDR_CTL1, 8'h07);
        wr_reg(ADDR_CTL1, 8'h03);
        b = 8'($urandom);
        wr_reg(ADDR_TXBUF, b);
        wait_until(1'b1);
        rd_reg(ADDR_RXST, 8'h40);
        rd_reg(ADDR_RXBUF, b);
        // Even parity beside a set address bit
        wr_reg(ADDR_FMT, 8'h6f);
        wr_reg(ADDR_CTL1, 8'h0b);
        b = 8'($urandom);
        wr_reg(ADDR_TXBUF, b);
        wait_until(1'b1);
        rd_reg(ADDR_RXST, 8'h42);
        rd_reg(ADDR_RXBUF, b);
        // Five data bits, two stops, idle-line
        wr_reg(ADDR_FMT, 8'h84);
        b = 8'($urandom);
        wr_reg(ADDR_TXBUF, b);
        wait_until(1'b1);
        rd_reg(ADDR_RXST, 8'h40);
        rd_reg(ADDR_RXBUF, b & 8'h1f);
        // Receiver disabled: frame assembles but never lands
        wr_reg(ADDR_CTL1, 8'h02);
        wr_reg(ADDR_TXBUF, 8'($urandom));
        repeat (120) @(posedge clk);
        rd_reg(ADDR_RXST, 8'h00);
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule : amw_uart_test
